// >>> verilog/shsc_standby_ctrl.sv
// Standby controller: HALT and STOP entry, release and peripheral gating
`timescale 1ns/100ps

// Summary of operation
// R1: HALT release: high priority, enable picks vector
// R2: Low priority vectors only with enable and in-service
// R3: STOP entered from either CPU clock source
// R4: Pending unmasked at STOP falls back to HALT
// R5: STOP halts main oscillator and CPU clock
// R6: Port latches hold their value in STOP
// R7: Listed timers, converter, multiplier stop in STOP
// R8: First timer counts only on external pin
// R9: Serial port runs only on running timer_b
// R10: Watchdog runs only if low-speed oscillator unstoppable
// R11: Protection and external interrupt functions stay alive
// R12: Software switches off high-speed oscillator before STOP
// R13: STOP wake waits settle, then vector or next
// R14: HALT release waits 8 or 2 clocks
// R15: Reset in STOP acts after settle time
// R16: Wake indication sampled every cycle in HALT and STOP, never lost
module shsc_standby_ctrl
  import shsc_pkg::*;
#(
  parameter int SETTLE_BASE_LOG2 = SHSC_SETTLE_BASE_LOG2_DEF
) (
  input wire logic clk, // 200 MHz system clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [3:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read request
  input wire logic avs_write, // Avalon write request
  input wire logic [31:0] avs_writedata, // Avalon write data
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic halt_instr, // HALT instruction executed, pulse
  input wire logic stop_instr, // STOP instruction executed, pulse
  input wire logic hs_int_osc_running, // Internal high-speed osc active
  input wire logic irq_req_flag, // Highest pending request flag
  input wire logic interrupt_mask_flag, // Its mask flag
  input wire logic priority_select_flag, // Its priority flag
  input wire logic global_irq_enable_flag, // Acknowledge enable
  input wire logic in_service_priority_flag, // In-service priority
  input wire logic reset_req, // Reset source asserted
  input wire logic timer_b_running, // Second 8-bit timer is counting
  input wire logic wdt_osc_unstoppable, // Option: low-speed osc fixed on
  output logic cpu_clk_en, // CPU clock supply enable
  output logic main_osc_en, // Crystal / high-speed osc enable
  output logic [7:0] port_latch, // Port output latches
  output logic inv_timer_run, // Inverter control timer enable
  output logic timer16_run, // 16-bit timer enable
  output logic timer_b_8bit_run, // Second 8-bit timer enable
  output logic rt_port_run, // Real-time output port enable
  output logic adc_run, // A/D converter enable
  output logic muldiv_run, // Multiplier/divider enable
  output logic timer_a_run, // First 8-bit timer enable
  output logic async_serial_port_run, // Async serial interface enable
  output logic wdt_run, // Watchdog enable
  output logic always_on_run, // Hi-Z ctrl, POC, LVI, ext int enable
  output logic resume_next, // Continue at next instruction, pulse
  output logic vector_take, // Start vectored servicing, pulse
  output logic reset_proc, // Start reset processing, pulse
  output logic [2:0] standby_state // Current controller state
);

  typedef struct packed {
    shsc_state_t st;
    logic fallback;
    logic take_vec;
    logic [2:0] osc_settle_select;
    logic timer_a_ext_count_pin;
    logic ser_clk_timer_b;
    logic stop_misuse;
    logic [7:0] port;
    logic ack;
    logic [31:0] rdata;
    logic low_pwr;
    logic cpu_clk_en;
    logic osc_en;
    logic resume;
    logic vector;
    logic rst_proc;
  } shsc_regs_t;

  localparam shsc_regs_t SHSC_REGS_RST = '{
    st: ST_RUN,
    fallback: 1'b0,
    take_vec: 1'b0,
    osc_settle_select: SHSC_SETTLE_SEL_RST,
    timer_a_ext_count_pin: 1'b0,
    ser_clk_timer_b: 1'b0,
    stop_misuse: 1'b0,
    port: SHSC_PORT_RST,
    ack: 1'b0,
    rdata: 32'h00000000,
    low_pwr: 1'b0,
    cpu_clk_en: 1'b1,
    osc_en: 1'b1,
    resume: 1'b0,
    vector: 1'b0,
    rst_proc: 1'b0
  };

  shsc_regs_t s_q;
  shsc_regs_t s_d;

  logic wake;
  logic take_now;
  logic settle_load;
  logic settle_zero;
  logic [SHSC_SETTLE_CNT_W-1:0] settle_val;
  logic wait_load;
  logic wait_zero;
  logic [SHSC_WAIT_CNT_W-1:0] wait_val;
  logic bus_req;
  logic [31:0] rd_mux;

  shsc_irq_decide u_decide (
    .irq_req_flag(irq_req_flag),
    .interrupt_mask_flag(interrupt_mask_flag),
    .priority_select_flag(priority_select_flag),
    .global_irq_enable_flag(global_irq_enable_flag),
    .in_service_priority_flag(in_service_priority_flag),
    .wake(wake),
    .take_vec(take_now)
  );

  shsc_down_counter #(
    .W(SHSC_SETTLE_CNT_W)
  ) u_settle_cnt (
    .clk(clk),
    .arst_n(arst_n),
    .load(settle_load),
    .load_val(settle_val),
    .zero(settle_zero)
  );

  shsc_down_counter #(
    .W(SHSC_WAIT_CNT_W)
  ) u_wait_cnt (
    .clk(clk),
    .arst_n(arst_n),
    .load(wait_load),
    .load_val(wait_val),
    .zero(wait_zero)
  );

  // Settle length follows the select field at the moment of loading
  assign settle_val = (SHSC_SETTLE_ONE << (SETTLE_BASE_LOG2 + int'(s_q.osc_settle_select)))
                      - SHSC_SETTLE_ONE;

  assign bus_req = avs_read | avs_write;

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (avs_address)
      SHSC_CFG_OFS: begin
        rd_mux[SHSC_CFG_SEL_LSB +: SHSC_CFG_SEL_W] = s_q.osc_settle_select;
        rd_mux[SHSC_CFG_EXT_PIN_BIT] = s_q.timer_a_ext_count_pin;
        rd_mux[SHSC_CFG_SER_TMRB_BIT] = s_q.ser_clk_timer_b;
      end
      SHSC_STAT_OFS: begin
        rd_mux[SHSC_STAT_ST_LSB +: 3] = 3'(s_q.st);
        rd_mux[SHSC_STAT_TAKE_BIT] = s_q.take_vec;
        rd_mux[SHSC_STAT_FALLBACK_BIT] = s_q.fallback;
        rd_mux[SHSC_STAT_MISUSE_BIT] = s_q.stop_misuse;
      end
      SHSC_PORT_OFS: begin
        rd_mux[7:0] = s_q.port;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.resume = 1'b0;
    s_d.vector = 1'b0;
    s_d.rst_proc = 1'b0;
    settle_load = 1'b0;
    wait_load = 1'b0;
    wait_val = SHSC_WAIT_NXT_LOAD;

    // One wait state: request seen, answer on the following edge
    s_d.ack = bus_req & ~s_q.ack;
    if (avs_read && !s_q.ack) begin
      s_d.rdata = rd_mux;
    end
    if (avs_write && s_q.ack && avs_byteenable[0]) begin
      unique case (avs_address)
        SHSC_CFG_OFS: begin
          s_d.osc_settle_select = avs_writedata[SHSC_CFG_SEL_LSB +: SHSC_CFG_SEL_W];
          s_d.timer_a_ext_count_pin = avs_writedata[SHSC_CFG_EXT_PIN_BIT];
          s_d.ser_clk_timer_b = avs_writedata[SHSC_CFG_SER_TMRB_BIT];
        end
        SHSC_STAT_OFS: begin
          if (avs_writedata[SHSC_STAT_MISUSE_BIT]) begin
            s_d.stop_misuse = 1'b0;
          end
        end
        SHSC_PORT_OFS: begin
          // Latches frozen while stopped
          if (!s_q.low_pwr) begin // R6
            s_d.port = avs_writedata[7:0];
          end
        end
        default: begin
          s_d.port = s_q.port;
        end
      endcase
    end

    // Wake is looked at every cycle in HALT and STOP, and in RUN on a HALT or STOP instruction
    unique case (s_q.st) // R16
      ST_RUN: begin
        if (stop_instr) begin
          // Flag misuse; set wins over a same-cycle clear
          if (hs_int_osc_running) begin // R12
            s_d.stop_misuse = 1'b1;
          end
          if (wake) begin // R4
            s_d.st = ST_SETTLE;
            s_d.fallback = 1'b1;
            settle_load = 1'b1;
          end else begin // R3
            s_d.st = ST_STOP;
            s_d.fallback = 1'b0;
          end
        end else if (halt_instr) begin
          if (wake) begin // R14
            s_d.st = ST_WAIT;
            s_d.take_vec = take_now;
            wait_load = 1'b1;
            wait_val = take_now ? SHSC_WAIT_VEC_LOAD : SHSC_WAIT_NXT_LOAD;
          end else begin
            s_d.st = ST_HALT;
          end
        end
      end
      ST_HALT: begin
        if (reset_req) begin
          s_d.st = ST_RUN;
          s_d.rst_proc = 1'b1;
        end else if (wake) begin // R1
          s_d.st = ST_WAIT;
          s_d.take_vec = take_now; // R2
          wait_load = 1'b1;
          wait_val = take_now ? SHSC_WAIT_VEC_LOAD : SHSC_WAIT_NXT_LOAD; // R14
        end
      end
      ST_STOP: begin
        if (reset_req) begin // R15
          s_d.st = ST_RST_SETTLE;
          settle_load = 1'b1;
        end else if (wake) begin // R13
          s_d.st = ST_SETTLE;
          settle_load = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (reset_req && !s_q.fallback) begin // R15
          s_d.st = ST_RST_SETTLE;
          settle_load = 1'b1;
        end else if (settle_zero) begin // R13
          s_d.st = ST_WAIT;
          s_d.fallback = 1'b0;
          s_d.take_vec = take_now;
          wait_load = 1'b1;
          wait_val = take_now ? SHSC_WAIT_VEC_LOAD : SHSC_WAIT_NXT_LOAD;
        end
      end
      ST_RST_SETTLE: begin
        if (settle_zero) begin // R15
          s_d.st = ST_RUN;
          s_d.rst_proc = 1'b1;
        end
      end
      ST_WAIT: begin
        if (wait_zero) begin
          s_d.st = ST_RUN;
          s_d.vector = s_q.take_vec; // R13
          s_d.resume = ~s_q.take_vec;
        end
      end
    endcase

    // Gating computed from the next state so outputs track state_q
    s_d.low_pwr = (s_d.st == ST_STOP) || (s_d.st == ST_RST_SETTLE) ||
                  ((s_d.st == ST_SETTLE) && !s_d.fallback);
    s_d.cpu_clk_en = (s_d.st == ST_RUN); // R5
    // Only the main oscillator stops; low-speed one is not ours
    s_d.osc_en = (s_d.st != ST_STOP); // R5
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= SHSC_REGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = bus_req & ~s_q.ack;
  assign avs_readdata = s_q.rdata;

  assign cpu_clk_en = s_q.cpu_clk_en;
  assign main_osc_en = s_q.osc_en;
  assign port_latch = s_q.port;
  assign standby_state = 3'(s_q.st);
  assign resume_next = s_q.resume;
  assign vector_take = s_q.vector;
  assign reset_proc = s_q.rst_proc;

  assign inv_timer_run = ~s_q.low_pwr; // R7
  assign timer16_run = ~s_q.low_pwr; // R7
  assign timer_b_8bit_run = ~s_q.low_pwr; // R7
  assign rt_port_run = ~s_q.low_pwr; // R7
  assign adc_run = ~s_q.low_pwr; // R7
  assign muldiv_run = ~s_q.low_pwr; // R7
  assign timer_a_run = ~s_q.low_pwr | s_q.timer_a_ext_count_pin; // R8
  // Serial port clocked by timer_b output can keep working
  assign async_serial_port_run = ~s_q.low_pwr |
                                 (s_q.ser_clk_timer_b & timer_b_running); // R9
  assign wdt_run = ~s_q.low_pwr | wdt_osc_unstoppable; // R10
  assign always_on_run = 1'b1; // R11

endmodule

// >>> verilog/shsc_pkg.sv
// Shared constants and types of the standby halt/stop controller
package shsc_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] SHSC_CFG_OFS = 4'h0;
  localparam logic [3:0] SHSC_STAT_OFS = 4'h4;
  localparam logic [3:0] SHSC_PORT_OFS = 4'h8;

  // Configuration register fields
  localparam int SHSC_CFG_SEL_LSB = 0;
  localparam int SHSC_CFG_SEL_W = 3;
  localparam int SHSC_CFG_EXT_PIN_BIT = 3;
  localparam int SHSC_CFG_SER_TMRB_BIT = 4;

  // Status register fields
  localparam int SHSC_STAT_ST_LSB = 0;
  localparam int SHSC_STAT_TAKE_BIT = 3;
  localparam int SHSC_STAT_FALLBACK_BIT = 4;
  localparam int SHSC_STAT_MISUSE_BIT = 5;

  // Reset values
  localparam logic [2:0] SHSC_SETTLE_SEL_RST = 3'h5;
  localparam logic [7:0] SHSC_PORT_RST = 8'h00;

  // Oscillation settle length is 2**(base + select) cycles
  localparam int SHSC_SETTLE_BASE_LOG2_DEF = 11;
  localparam int SHSC_SETTLE_CNT_W = 20;
  localparam logic [SHSC_SETTLE_CNT_W-1:0] SHSC_SETTLE_ONE = 20'h00001;

  // Wait after a halt release, in clocks
  localparam int SHSC_WAIT_CNT_W = 4;
  localparam int SHSC_WAIT_VEC_CYC = 8;
  localparam int SHSC_WAIT_NXT_CYC = 2;
  localparam logic [SHSC_WAIT_CNT_W-1:0] SHSC_WAIT_VEC_LOAD = 4'(SHSC_WAIT_VEC_CYC - 1);
  localparam logic [SHSC_WAIT_CNT_W-1:0] SHSC_WAIT_NXT_LOAD = 4'(SHSC_WAIT_NXT_CYC - 1);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_SETTLE,
    ST_RST_SETTLE,
    ST_WAIT
  } shsc_state_t;

endpackage

// >>> verilog/shsc_irq_decide.sv
// Wake and vector decision for the highest pending maskable request
`timescale 1ns/100ps
module shsc_irq_decide (
  input wire logic irq_req_flag, // Request flag of the pending source
  input wire logic interrupt_mask_flag, // Mask flag of that source
  input wire logic priority_select_flag, // 1 = low priority
  input wire logic global_irq_enable_flag, // Acknowledge enable
  input wire logic in_service_priority_flag, // In-service priority
  output logic wake, // Unmasked request present
  output logic take_vec // Request will be vectored
);

  // Masked request never wakes, so standby stays held
  assign wake = irq_req_flag & ~interrupt_mask_flag; // R1

  // Low priority needs both enable and in-service flag set
  assign take_vec = wake & (priority_select_flag ?
                    (global_irq_enable_flag & in_service_priority_flag) : // R2
                    global_irq_enable_flag); // R1

endmodule

// >>> verilog/shsc_down_counter.sv
// Loadable down counter used for settle and release waits
`timescale 1ns/100ps
module shsc_down_counter #(
  parameter int W = 4
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic load, // Load strobe
  input wire logic [W-1:0] load_val, // Value to load
  output logic zero // Count has reached zero
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } shsc_cnt_t;

  shsc_cnt_t cnt_q;
  shsc_cnt_t cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d.cnt = load_val;
    end else if (cnt_q.cnt != '0) begin
      cnt_d.cnt = cnt_q.cnt - W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign zero = (cnt_q.cnt == '0);

endmodule

// >>> verification/shsc_properties.sv
// Port-level assertions of the standby controller
`timescale 1ns/100ps
module shsc_properties
  import shsc_pkg::*;
#(
  parameter int SETTLE_BASE_LOG2 = 1
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic stop_instr, // STOP
  input wire logic irq_req_flag, // Request
  input wire logic interrupt_mask_flag, // Mask
  input wire logic priority_select_flag, // Priority
  input wire logic global_irq_enable_flag, // Enable
  input wire logic in_service_priority_flag, // In service
  input wire logic reset_req, // Reset source
  input wire logic wdt_osc_unstoppable, // Option
  input wire logic cpu_clk_en, // CPU clock
  input wire logic main_osc_en, // Main osc
  input wire logic [7:0] port_latch, // Ports
  input wire logic adc_run, // ADC
  input wire logic muldiv_run, // Mul/div
  input wire logic wdt_run, // Watchdog
  input wire logic always_on_run, // Always on
  input wire logic resume_next, // Next
  input wire logic vector_take, // Vector
  input wire logic reset_proc, // Reset start
  input wire logic [2:0] standby_state // State
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic wake;
  logic go;
  logic vec;
  logic stp;
  assign wake = irq_req_flag & ~interrupt_mask_flag;
  assign go = wake & ~reset_req;
  assign vec = global_irq_enable_flag & (~priority_select_flag | in_service_priority_flag);
  assign stp = standby_state == ST_STOP;
  sequence s_halt_go;
    standby_state == ST_HALT && go;
  endsequence
  sequence s_wait8;
    standby_state == ST_WAIT [*8];
  endsequence
  sequence s_wait2;
    standby_state == ST_WAIT [*2];
  endsequence
  property p_halt_vec;
    s_halt_go ##0 vec |-> ##1 s_wait8 ##1 vector_take;
  endproperty
  property p_halt_next;
    s_halt_go ##0 !vec |-> ##1 s_wait2 ##1 resume_next;
  endproperty
  property p_halt_hold;
    standby_state == ST_HALT && interrupt_mask_flag && !reset_req |=> standby_state == ST_HALT;
  endproperty
  property p_stop_in;
    standby_state == ST_RUN && stop_instr && !wake && !reset_req |=> stp;
  endproperty
  property p_fall;
    standby_state == ST_RUN && stop_instr && go |=> standby_state == ST_SETTLE && main_osc_en;
  endproperty
  property p_clk;
    stp |-> !cpu_clk_en && !main_osc_en;
  endproperty
  property p_port;
    stp |=> $stable(port_latch);
  endproperty
  property p_gate;
    stp && $past(stp) |-> !adc_run && !muldiv_run && wdt_run == wdt_osc_unstoppable;
  endproperty
  property p_alive;
    always_on_run;
  endproperty
  property p_wake;
    stp && go |=> standby_state == ST_SETTLE;
  endproperty
  property p_rst;
    stp && reset_req |=> standby_state == ST_RST_SETTLE && !reset_proc;
  endproperty
  a_halt_vec: assert property (p_halt_vec) else $error("halt vector release wrong");
  a_halt_next: assert property (p_halt_next) else $error("halt resume release wrong");
  a_halt_hold: assert property (p_halt_hold) else $error("masked request left halt");
  a_stop_in: assert property (p_stop_in) else $error("stop not entered");
  a_fall: assert property (p_fall) else $error("no fallback to halt");
  a_clk: assert property (p_clk) else $error("clock running in stop");
  a_port: assert property (p_port) else $error("port latch moved in stop");
  a_gate: assert property (p_gate) else $error("peripheral gating wrong");
  a_alive: assert property (p_alive) else $error("always-on functions gated");
  a_wake: assert property (p_wake) else $error("stop wake did not settle");
  a_rst: assert property (p_rst) else $error("reset in stop not delayed");
endmodule

bind shsc_standby_ctrl shsc_properties #(.SETTLE_BASE_LOG2(SETTLE_BASE_LOG2)) u_props (
  .clk, .arst_n, .stop_instr, .irq_req_flag, .interrupt_mask_flag, .priority_select_flag,
  .global_irq_enable_flag, .in_service_priority_flag, .reset_req, .wdt_osc_unstoppable,
  .cpu_clk_en, .main_osc_en, .port_latch, .adc_run, .muldiv_run, .wdt_run, .always_on_run,
  .resume_next, .vector_take, .reset_proc, .standby_state
);

// >>> verification/shsc_cpu_model.sv
// Partner model: CPU core and interrupt controller
`timescale 1ns/100ps
module shsc_cpu_model (
  input wire logic clk, // Clock
  input wire logic vector_take, // Servicing starts
  output logic halt_instr, // HALT pulse
  output logic stop_instr, // STOP pulse
  output logic hs_int_osc_running, // Fast osc on
  output logic [4:0] irq, // Req, mask, prio, enable, in-service
  output logic reset_req, // Reset source
  output logic timer_b_running, // Timer b counts
  output logic wdt_osc_unstoppable // Option bit
);
  initial begin
    {halt_instr, stop_instr, hs_int_osc_running, irq, reset_req} = '0;
    {timer_b_running, wdt_osc_unstoppable} = 2'h0;
  end
  // Serviced request is acknowledged and dropped
  always @(posedge clk) begin
    if (vector_take) begin
      irq[4] <= 1'b0;
    end
  end
  task automatic instr(input logic stop);
    if (stop && hs_int_osc_running) begin
      hs_int_osc_running <= 1'b0;
      @(posedge clk);
    end
    halt_instr <= ~stop;
    stop_instr <= stop;
    @(posedge clk);
    halt_instr <= 1'b0;
    stop_instr <= 1'b0;
  endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench of the standby controller
`timescale 1ns/100ps
module testbench;
  import shsc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic halt_instr, stop_instr, hs_int_osc_running, reset_req, timer_b_running;
  logic wdt_osc_unstoppable, cpu_clk_en, main_osc_en, inv_timer_run, timer16_run;
  logic timer_b_8bit_run, rt_port_run, adc_run, muldiv_run, timer_a_run, wdt_run;
  logic async_serial_port_run, always_on_run, resume_next, vector_take, reset_proc;
  logic [4:0] irq;
  logic [7:0] port_latch;
  logic [2:0] standby_state;
  logic [31:0] rd;
  logic [31:0] lfsr_q = 32'hD99E8BEE;
  logic [2:0] exp_q[$];
  logic [15:0] tbl[6] = '{16'h0430, 16'h0A52, 16'h0435, 16'h0434, 16'h0A57, 16'h0436};
  int n_errors = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  shsc_standby_ctrl #(.SETTLE_BASE_LOG2(1)) u_shsc_standby_ctrl (
    .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .halt_instr, .stop_instr, .hs_int_osc_running,
    .irq_req_flag(irq[4]), .interrupt_mask_flag(irq[3]), .priority_select_flag(irq[2]),
    .global_irq_enable_flag(irq[1]), .in_service_priority_flag(irq[0]), .reset_req,
    .timer_b_running, .wdt_osc_unstoppable, .cpu_clk_en, .main_osc_en, .port_latch,
    .inv_timer_run, .timer16_run, .timer_b_8bit_run, .rt_port_run, .adc_run, .muldiv_run,
    .timer_a_run, .async_serial_port_run, .wdt_run, .always_on_run, .resume_next,
    .vector_take, .reset_proc, .standby_state
  );
  shsc_cpu_model u_shsc_cpu_model (
    .clk, .vector_take, .halt_instr, .stop_instr, .hs_int_osc_running, .irq, .reset_req,
    .timer_b_running, .wdt_osc_unstoppable
  );

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 200) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    guard(n);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  // Edges from the call to the release pulse; the monitor judges its kind
  task automatic pulse(input logic [2:0] kind, input int lat);
    int n;
    n = 0;
    exp_q.push_back(kind);
    do begin
      @(posedge clk);
      n++;
    end while ({reset_proc, vector_take, resume_next} === 3'h0 && n < 200);
    guard(n);
    check("latency", n, lat);
    @(posedge clk);
    u_shsc_cpu_model.irq <= 5'h00;
  endtask

  task automatic rst(input int lat);
    u_shsc_cpu_model.reset_req <= 1'b1;
    @(posedge clk);
    u_shsc_cpu_model.reset_req <= 1'b0;
    pulse(3'h4, lat);
  endtask

  always @(posedge clk) begin
    if (arst_n && {reset_proc, vector_take, resume_next} !== 3'h0) begin
      check("release", 32'({reset_proc, vector_take, resume_next}), 32'(exp_q.pop_front()));
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'hC, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, SHSC_CFG_OFS, 32'h2);
    foreach (tbl[i]) begin
      u_shsc_cpu_model.instr(1'b0);
      u_shsc_cpu_model.irq <= tbl[i][4:0];
      pulse(tbl[i][7:5], tbl[i][15:8]);
    end
    u_shsc_cpu_model.instr(1'b0);
    u_shsc_cpu_model.irq <= 5'h1B;
    repeat (6) @(posedge clk);
    check("held", 32'(standby_state), 32'(ST_HALT));
    rst(1);
    for (int i = 0; i < 2; i++) begin
      lfsr_q = lfsr(lfsr_q);
      u_shsc_cpu_model.timer_b_running <= lfsr_q[5];
      u_shsc_cpu_model.wdt_osc_unstoppable <= lfsr_q[6];
      u_shsc_cpu_model.hs_int_osc_running <= lfsr_q[7];
      bus(1'b1, SHSC_CFG_OFS, {27'h0, lfsr_q[4:3], 3'h2});
      bus(1'b1, SHSC_PORT_OFS, {24'h0, lfsr_q[15:8]});
      u_shsc_cpu_model.instr(1'b1);
      repeat (2) @(posedge clk);
      check("state", 32'(standby_state), 32'(ST_STOP));
      check("gated", 32'({inv_timer_run, timer16_run, timer_b_8bit_run, rt_port_run, adc_run,
        muldiv_run, cpu_clk_en, main_osc_en}), 32'h0);
      check("kept", 32'({timer_a_run, async_serial_port_run, wdt_run, always_on_run}),
        32'({lfsr_q[3], lfsr_q[4] & lfsr_q[5], lfsr_q[6], 1'b1}));
      // Port writes are refused while the latches are frozen
      bus(1'b1, SHSC_PORT_OFS, ~lfsr_q);
      check("port", 32'(port_latch), 32'(lfsr_q[15:8]));
      u_shsc_cpu_model.irq <= {3'h4, i[0], 1'b0};
      // Settle of 8 cycles, then a wait of 8 (vector) or 2 (next)
      pulse({1'b0, i[0], ~i[0]}, i[0] ? 18 : 12);
    end
    u_shsc_cpu_model.irq <= 5'h10;
    u_shsc_cpu_model.instr(1'b1);
    @(posedge clk);
    check("fallback", 32'({main_osc_en, standby_state}), 32'({1'b1, ST_SETTLE}));
    // Status read while the fallback settle still runs; the flag drops at its end
    bus(1'b0, SHSC_STAT_OFS, 32'h0);
    check("fallback flag", 32'(rd[SHSC_STAT_FALLBACK_BIT]), 32'h1);
    check("fallback state", 32'(rd[SHSC_STAT_ST_LSB +: 3]), 32'(ST_SETTLE));
    pulse(3'h1, 7);
    u_shsc_cpu_model.instr(1'b1);
    rst(9);
    // Write with lane 0 disabled must leave the configuration alone
    avs_byteenable <= {lfsr_q[2:0], 1'b0};
    bus(1'b1, SHSC_CFG_OFS, 32'h1F);
    avs_byteenable <= 4'hF;
    bus(1'b0, SHSC_CFG_OFS, 32'h0);
    check("lane0 off", rd, {27'h0, lfsr_q[4:3], 3'h2});
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, SHSC_CFG_OFS, 32'h0);
    check("cfg reset", rd, 32'h5);
    bus(1'b0, SHSC_PORT_OFS, 32'h0);
    check("port reset", rd, 32'h0);
    check("pending", exp_q.size(), 32'h0);
    end_of_test();
  end
endmodule
